/* design/via_elem_alu.sv */
// Per-element integer add and subtract datapath
`timescale 1ns/1ps
module via_elem_alu (
   // Operation select
   input  wire via_pkg::via_op_e         op_i,
   input  wire logic                     j_zero_i,
   // Operands
   input  wire logic [via_pkg::DATA_W-1:0] scalar_i,
   input  wire logic [via_pkg::DATA_W-1:0] vec_j_i,
   input  wire logic [via_pkg::DATA_W-1:0] vec_k_i,
   // Result
   output logic      [via_pkg::DATA_W-1:0] result_o
);

   logic [via_pkg::DATA_W-1:0] s_term;  // Scalar term after j check

   // ***************************************************************
   // Element arithmetic
   // ***************************************************************
   // Wraps mod 2^64; carries out of the top bit are simply lost
   always_comb begin
      s_term = j_zero_i ? '0 : scalar_i;
      case (op_i)
         via_pkg::VIA_OP_ADD_SV: result_o = s_term + vec_k_i;
         via_pkg::VIA_OP_ADD_VV: result_o = vec_j_i + vec_k_i;
         via_pkg::VIA_OP_SUB_SV: result_o = s_term - vec_k_i;
         default:                result_o = vec_j_i - vec_k_i;
      endcase
   end

endmodule

/* design/via_top.sv */
// Vector integer add functional unit: sequencer, operand reads, writes
//
// What this block does
// - Scalar plus vector: add scalar to each element
// - Scalar designator zero: copy vector unchanged
// - Vector plus vector: add same-index elements
// - Scalar minus vector: scalar less each element
// - Scalar designator zero: write negated elements
// - Vector minus vector: first less second elementwise
// - Element operations equal count at issue
// - Only opcodes in add range run here
`timescale 1ns/1ps
module via_top (
   // Clock and reset
   input  wire logic                        ref_clk_i,
   input  wire logic                        reset_n_i,
   // Issue port
   input  wire logic                        issue_valid_i,
   input  wire logic [via_pkg::INSTR_W-1:0] issue_instr_i,
   input  wire logic [via_pkg::DATA_W-1:0]  scalar_operand_i,
   input  wire logic [via_pkg::CNT_W-1:0]   element_count_register_i,
   output logic                             issue_ready_o,
   output logic                             issue_accept_o,
   // Vector register file read
   output logic                             rd_en_o,
   output logic      [via_pkg::REG_W-1:0]   rd_first_vector_operand_o,
   output logic      [via_pkg::REG_W-1:0]   rd_second_vector_operand_o,
   output logic      [via_pkg::IDX_W-1:0]   rd_idx_o,
   input  wire logic [via_pkg::DATA_W-1:0]  rd_first_data_i,
   input  wire logic [via_pkg::DATA_W-1:0]  rd_second_data_i,
   // Vector register file write
   output logic                             wr_en_o,
   output logic      [via_pkg::REG_W-1:0]   wr_destination_vector_o,
   output logic      [via_pkg::IDX_W-1:0]   wr_idx_o,
   output logic      [via_pkg::DATA_W-1:0]  wr_data_o,
   // Status
   output logic                             busy_o,
   output logic                             done_o
);

   via_pkg::via_ctl_s             cur_ff;    // Registered state
   via_pkg::via_ctl_s             nxt_ctl;   // Next state
   logic [6:0]                    opcode;    // Opcode field
   logic                          in_range;  // Opcode belongs here
   logic                          take;      // Instruction taken
   logic                          last_el;   // Final element this cycle
   logic [via_pkg::DATA_W-1:0]    alu_res;   // Element result

   localparam int unsigned CNT_W = via_pkg::CNT_W;  // Local width alias

   // ***************************************************************
   // Decode
   // ***************************************************************
   // Field split of the instruction word
   assign opcode = issue_instr_i[via_pkg::OPC_MSB:via_pkg::OPC_LSB];
   // Other vector opcodes are never claimed, so no other unit sees a clash
   assign in_range = (opcode >= via_pkg::OPC_ADD_SV)
                   && (opcode <= via_pkg::OPC_SUB_VV);
   assign take     = issue_valid_i && issue_ready_o && in_range;
   // Count of done elements reaches the captured count
   assign last_el  = (CNT_W'({1'b0, cur_ff.idx}) + CNT_W'(1)) == cur_ff.count;

   // ***************************************************************
   // Handshake and read port, combinational from state and issue inputs
   // ***************************************************************
   assign issue_ready_o              = (cur_ff.st == via_pkg::VIA_ST_IDLE);
   assign issue_accept_o             = take;
   assign rd_en_o                    = (cur_ff.st == via_pkg::VIA_ST_RUN);
   assign rd_first_vector_operand_o  = cur_ff.srj;
   assign rd_second_vector_operand_o = cur_ff.srk;
   assign rd_idx_o                   = cur_ff.idx;
   assign busy_o                     = (cur_ff.st == via_pkg::VIA_ST_RUN);

   // Data outputs straight from flops
   assign wr_en_o                 = cur_ff.wr_en;
   assign wr_destination_vector_o = cur_ff.wr_reg;
   assign wr_idx_o                = cur_ff.wr_idx;
   assign wr_data_o               = cur_ff.wr_data;
   assign done_o                  = cur_ff.done;

   // ***************************************************************
   // Element datapath
   // ***************************************************************
   via_elem_alu u_alu (
      .op_i     (cur_ff.op),
      .j_zero_i (cur_ff.j_zero),
      .scalar_i (cur_ff.scalar),
      .vec_j_i  (rd_first_data_i),
      .vec_k_i  (rd_second_data_i),
      .result_o (alu_res)
   );

   // ***************************************************************
   // Sequencer next state
   // ***************************************************************
   always_comb begin
      nxt_ctl       = cur_ff;
      nxt_ctl.wr_en = 1'b0;   // Strobes last one cycle
      nxt_ctl.done  = 1'b0;
      case (cur_ff.st)
         via_pkg::VIA_ST_IDLE: begin
            if (take) begin
               // Capture everything at issue so later changes do not matter
               nxt_ctl.op     = via_pkg::via_op_e'(opcode[1:0]);
               nxt_ctl.dst    = issue_instr_i[via_pkg::DST_LSB +: via_pkg::REG_W];
               nxt_ctl.srj    = issue_instr_i[via_pkg::SRJ_LSB +: via_pkg::REG_W];
               nxt_ctl.srk    = issue_instr_i[via_pkg::SRK_LSB +: via_pkg::REG_W];
               nxt_ctl.j_zero = (issue_instr_i[via_pkg::SRJ_LSB +: via_pkg::REG_W]
                                 == 3'h0);
               nxt_ctl.scalar = scalar_operand_i;
               nxt_ctl.count  = element_count_register_i;
               nxt_ctl.idx    = '0;
               if (element_count_register_i == 7'h00) begin
                  // Zero length: nothing written, finish at once
                  nxt_ctl.done = 1'b1;
               end else begin
                  nxt_ctl.st = via_pkg::VIA_ST_RUN;
               end
            end
         end
         via_pkg::VIA_ST_RUN: begin
            // One element per cycle; indices past count never written
            nxt_ctl.wr_en   = 1'b1;
            nxt_ctl.wr_reg  = cur_ff.dst;
            nxt_ctl.wr_idx  = cur_ff.idx;
            nxt_ctl.wr_data = alu_res;
            if (last_el) begin
               nxt_ctl.st   = via_pkg::VIA_ST_IDLE;
               nxt_ctl.done = 1'b1;
            end else begin
               nxt_ctl.idx = cur_ff.idx + 6'h01;
            end
         end
         default: begin
            nxt_ctl = via_pkg::VIA_CTL_RST;
         end
      endcase
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         cur_ff <= via_pkg::VIA_CTL_RST;
      end else begin
         cur_ff <= nxt_ctl;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   logic [7:0] wr_seen_ff;  // Writes since the last issue
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         wr_seen_ff <= 8'h00;
      end else if (take) begin
         wr_seen_ff <= 8'h00;
      end else if (wr_en_o) begin
         wr_seen_ff <= wr_seen_ff + 8'h01;
      end
   end

   // One element read then written the next cycle
   sequence s_read(via_pkg::via_op_e o, logic jz);
      rd_en_o && cur_ff.op == o && cur_ff.j_zero == jz;
   endsequence

   property p_add_sv;
      s_read(via_pkg::VIA_OP_ADD_SV, 1'b0) |=>
         wr_en_o && wr_data_o == $past(cur_ff.scalar + rd_second_data_i);
   endproperty
   a_add_sv: assert property (p_add_sv) else $error("scalar add wrong");

   property p_copy;
      s_read(via_pkg::VIA_OP_ADD_SV, 1'b1) |=> wr_data_o == $past(rd_second_data_i);
   endproperty
   a_copy: assert property (p_copy) else $error("copy form wrong");

   property p_add_vv;
      s_read(via_pkg::VIA_OP_ADD_VV, 1'b0) or s_read(via_pkg::VIA_OP_ADD_VV, 1'b1) |=>
         wr_data_o == $past(rd_first_data_i + rd_second_data_i);
   endproperty
   a_add_vv: assert property (p_add_vv) else $error("vector add wrong");

   property p_sub_sv;
      s_read(via_pkg::VIA_OP_SUB_SV, 1'b0) |=>
         wr_data_o == $past(cur_ff.scalar - rd_second_data_i);
   endproperty
   a_sub_sv: assert property (p_sub_sv) else $error("scalar sub wrong");

   property p_negate;
      s_read(via_pkg::VIA_OP_SUB_SV, 1'b1) |=> wr_data_o == 64'h0 - $past(rd_second_data_i);
   endproperty
   a_negate: assert property (p_negate) else $error("negate wrong");

   property p_sub_vv;
      s_read(via_pkg::VIA_OP_SUB_VV, 1'b0) or s_read(via_pkg::VIA_OP_SUB_VV, 1'b1) |=>
         wr_data_o == $past(rd_first_data_i - rd_second_data_i);
   endproperty
   a_sub_vv: assert property (p_sub_vv) else $error("vector sub wrong");

   property p_count;
      done_o |-> wr_seen_ff[6:0] + {6'h00, wr_en_o} == cur_ff.count;
   endproperty
   a_count: assert property (p_count) else $error("element count mismatch");

   property p_range;
      issue_valid_i && issue_ready_o && !in_range |=> !busy_o && !done_o;
   endproperty
   a_range: assert property (p_range) else $error("foreign opcode executed");

   property p_dest;
      take && element_count_register_i != 7'h00 |=> ##1
         wr_en_o && wr_destination_vector_o == $past(issue_instr_i[8:6], 2) && wr_idx_o == 6'h00;
   endproperty
   a_dest: assert property (p_dest) else $error("destination field wrong");

   property p_bound;
      wr_en_o |-> {1'b0, wr_idx_o} < cur_ff.count;
   endproperty
   a_bound: assert property (p_bound) else $error("write past element count");

endmodule

/* pkg/via_pkg.sv */
// Constants, types and state layout for the vector integer add unit
package via_pkg;

   // ***************************************************************
   // Widths
   // ***************************************************************
   localparam int unsigned DATA_W  = 64;  // Element width
   localparam int unsigned INSTR_W = 16;  // Instruction word width
   localparam int unsigned REG_W   = 3;   // Register designator width
   localparam int unsigned IDX_W   = 6;   // Element index width
   localparam int unsigned CNT_W   = 7;   // Element count width, 0..64

   // ***************************************************************
   // Instruction field positions
   // ***************************************************************
   localparam int unsigned OPC_MSB = 15;  // Opcode top bit
   localparam int unsigned OPC_LSB = 9;   // Opcode low bit
   localparam int unsigned DST_LSB = 6;   // Destination designator
   localparam int unsigned SRJ_LSB = 3;   // First operand designator
   localparam int unsigned SRK_LSB = 0;   // Second vector operand designator

   // ***************************************************************
   // Opcodes routed to this unit
   // ***************************************************************
   localparam logic [6:0] OPC_ADD_SV = 7'h6C;  // Scalar plus vector
   localparam logic [6:0] OPC_SUB_VV = 7'h6F;  // Vector minus vector

   // Operation kind, low two opcode bits
   typedef enum logic [1:0] {
      VIA_OP_ADD_SV = 2'b00,
      VIA_OP_ADD_VV = 2'b01,
      VIA_OP_SUB_SV = 2'b10,
      VIA_OP_SUB_VV = 2'b11
   } via_op_e;

   // Sequencer states
   typedef enum logic [0:0] {
      VIA_ST_IDLE = 1'b0,
      VIA_ST_RUN  = 1'b1
   } via_st_e;

   // Whole state of the unit
   typedef struct packed {
      via_st_e             st;       // Sequencer state
      via_op_e             op;       // Latched operation
      logic [REG_W-1:0]    dst;      // Destination vector
      logic [REG_W-1:0]    srj;      // First operand designator
      logic [REG_W-1:0]    srk;      // Second vector operand
      logic                j_zero;   // Designator j was zero
      logic [DATA_W-1:0]   scalar;   // Captured scalar operand
      logic [CNT_W-1:0]    count;    // Captured element count
      logic [IDX_W-1:0]    idx;      // Element being read
      logic                wr_en;    // Write strobe
      logic [REG_W-1:0]    wr_reg;   // Write register
      logic [IDX_W-1:0]    wr_idx;   // Write element index
      logic [DATA_W-1:0]   wr_data;  // Write data
      logic                done;     // Completion pulse
   } via_ctl_s;

   localparam via_ctl_s VIA_CTL_RST = '0;  // Reset value of whole state

endpackage

/* sim/testbench.sv */
// Self-checking bench for the vector integer add unit
`timescale 1ns/1ps
module testbench;
   // ***************************************************************
   // Signals
   // ***************************************************************
   typedef struct {
      logic [6:0] opc; logic [2:0] dst; logic [2:0] j; logic [2:0] k;
      logic [63:0] scl; logic [6:0] cnt;
   } via_row_s;
   logic ref_clk = 1'b0, reset_n = 1'b0, valid = 1'b0;
   logic [15:0] instr = 16'h0;
   logic [63:0] scl = 64'h0, rdj, rdk, wr_data, ref_mem [8][64];
   logic [6:0] cnt = 7'h0, wr_cnt_ff = 7'h0, wr_last_ff = 7'h0;
   logic ready, accept, rd_en, wr_en, busy, done;
   logic [2:0] rd_j, rd_k, wr_reg;
   logic [5:0] rd_idx, wr_idx;
   int num_errors = 0, total_checks = 0;
   via_row_s rows [7] = '{
      '{7'h6C, 3'h1, 3'h2, 3'h3, 64'hFFFF_FFFF_FFFF_FFFF, 7'h05},
      '{7'h6C, 3'h4, 3'h0, 3'h3, 64'h1234, 7'h03},
      '{7'h6D, 3'h5, 3'h1, 3'h2, 64'h0, 7'h40},
      '{7'h6E, 3'h6, 3'h3, 3'h4, 64'h10, 7'h07},
      '{7'h6E, 3'h7, 3'h0, 3'h1, 64'h55, 7'h02},
      '{7'h6F, 3'h0, 3'h5, 3'h6, 64'h0, 7'h01},
      '{7'h6D, 3'h2, 3'h6, 3'h7, 64'h0, 7'h00}};

   // 200 MHz clock
   always #2.5 ref_clk = ~ref_clk;

   via_top DUT (.ref_clk_i(ref_clk), .reset_n_i(reset_n), .issue_valid_i(valid),
      .issue_instr_i(instr), .scalar_operand_i(scl), .element_count_register_i(cnt),
      .issue_ready_o(ready), .issue_accept_o(accept), .rd_en_o(rd_en),
      .rd_first_vector_operand_o(rd_j), .rd_second_vector_operand_o(rd_k),
      .rd_idx_o(rd_idx), .rd_first_data_i(rdj), .rd_second_data_i(rdk),
      .wr_en_o(wr_en), .wr_destination_vector_o(wr_reg), .wr_idx_o(wr_idx),
      .wr_data_o(wr_data), .busy_o(busy), .done_o(done));
   via_vrf_model model (.ref_clk_i(ref_clk), .rd_en_i(rd_en), .rd_j_i(rd_j),
      .rd_k_i(rd_k), .rd_idx_i(rd_idx), .rd_j_data_o(rdj), .rd_k_data_o(rdk),
      .wr_en_i(wr_en), .wr_reg_i(wr_reg), .wr_idx_i(wr_idx), .wr_data_i(wr_data));

   // Write strobes per instruction, latched when done pulses; cleared in reset
   always @(posedge ref_clk) begin
      wr_cnt_ff <= (done === 1'b1 || reset_n !== 1'b1) ? 7'h0 : wr_cnt_ff + 7'(wr_en);
      if (done === 1'b1) wr_last_ff <= wr_cnt_ff + 7'(wr_en);
   end

   // ***************************************************************
   // Helpers
   // ***************************************************************
   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: data %h, expected %h", $time, got, exp);
      end
   endtask
   // Expected element result, wrapping at 64 bits
   function automatic logic [63:0] calc(via_row_s r, logic [63:0] a, logic [63:0] b);
      logic [63:0] sv;
      sv = (r.j == 3'h0) ? 64'h0 : r.scl;
      case (r.opc[1:0])
         2'h0: return sv + b;
         2'h1: return a + b;
         2'h2: return sv - b;
         default: return a - b;
      endcase
   endfunction
   // Offer an instruction until taken; nothing may be taken while busy
   task automatic issue(input via_row_s r);
      int n;
      @(negedge ref_clk);
      valid = 1'b1;
      instr = {r.opc, r.dst, r.j, r.k};
      scl = r.scl;
      cnt = r.cnt;
      n = 0;
      #1;
      while (accept !== 1'b1 && n < 200) begin
         if (busy === 1'b1) chk_bit(accept, 1'b0);
         @(negedge ref_clk);
         #1;
         n++;
      end
      chk_bit(accept, 1'b1);
      // Held offer is taken in the very cycle the previous one ends
      if (n > 0) chk_bit(done, 1'b1);
      for (int e = 0; e < r.cnt; e++) ref_mem[r.dst][e] = calc(r, ref_mem[r.j][e], ref_mem[r.k][e]);
      @(negedge ref_clk);
      valid = 1'b0;
   endtask
   // Wait for completion, then check counts and the whole destination
   task automatic finish_op(input via_row_s r);
      int n;
      n = 0;
      while (done !== 1'b1 && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
      chk_bit(done, 1'b1);
      @(posedge ref_clk);
      #1;
      chk_dest(r);
   endtask
   // Count of writes and the whole destination, once the instruction has ended
   task automatic chk_dest(input via_row_s r);
      chk_bit(wr_last_ff == r.cnt, 1'b1);
      for (int e = 0; e < 64; e++) chk_word(model.mem_ff[r.dst][e], ref_mem[r.dst][e]);
   endtask
   // An opcode outside the add range is never taken
   task automatic offer_bad(input logic [6:0] opc);
      @(negedge ref_clk);
      valid = 1'b1;
      instr = {opc, 9'h0CB};
      cnt = 7'h04;
      repeat (3) begin
         #1;
         chk_bit(accept, 1'b0);
         chk_bit(busy, 1'b0);
         @(negedge ref_clk);
      end
      valid = 1'b0;
   endtask
   task automatic test_done;
      $display("checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ***************************************************************
   // Sequence
   // ***************************************************************
   initial begin
      for (int r = 0; r < 8; r++) begin
         for (int e = 0; e < 64; e++) begin
            ref_mem[r][e] = 64'h8000_0000_0000_0000 ^ (64'(r) << 56) ^ (64'(e) * 64'h0101_0101_0101_0101);
            model.mem_ff[r][e] = ref_mem[r][e];
         end
      end
      repeat (6) @(negedge ref_clk);
      chk_bit(ready, 1'b1);
      chk_bit(busy | wr_en | done | accept, 1'b0);
      reset_n = 1'b1;
      foreach (rows[i]) begin
         issue(rows[i]);
         finish_op(rows[i]);
      end
      // Longest count, then a second offer held through the busy span
      issue(rows[2]);
      issue(rows[0]);
      // First one ended on the edge that took the second: its done has passed
      chk_dest(rows[2]);
      finish_op(rows[0]);
      // Reset in mid-instruction: back to idle, then a clean rerun
      issue(rows[3]);
      repeat (2) @(negedge ref_clk);
      reset_n = 1'b0;
      @(negedge ref_clk);
      chk_bit(ready, 1'b1);
      chk_bit(busy | wr_en | done, 1'b0);
      reset_n = 1'b1;
      issue(rows[3]);
      finish_op(rows[3]);
      offer_bad(7'h6B);
      offer_bad(7'h70);
      test_done();
   end

   // Watchdog, well past the expected run time
   initial begin
      #100us;
      num_errors++;
      test_done();
   end
endmodule

/* sim/via_vrf_model.sv */
// Behavioural vector register file standing behind the add unit
`timescale 1ns/1ps
module via_vrf_model (
   // Clock
   input  wire logic                        ref_clk_i,
   // Read side, answered in the same cycle
   input  wire logic                        rd_en_i,
   input  wire logic [via_pkg::REG_W-1:0]   rd_j_i,
   input  wire logic [via_pkg::REG_W-1:0]   rd_k_i,
   input  wire logic [via_pkg::IDX_W-1:0]   rd_idx_i,
   output logic      [via_pkg::DATA_W-1:0]  rd_j_data_o,
   output logic      [via_pkg::DATA_W-1:0]  rd_k_data_o,
   // Write side, one element per strobe
   input  wire logic                        wr_en_i,
   input  wire logic [via_pkg::REG_W-1:0]   wr_reg_i,
   input  wire logic [via_pkg::IDX_W-1:0]   wr_idx_i,
   input  wire logic [via_pkg::DATA_W-1:0]  wr_data_i
);
   // ***************************************************************
   // Storage
   // ***************************************************************
   logic [via_pkg::DATA_W-1:0] mem_ff [8][64];  // Preloaded by the bench
   logic [via_pkg::DATA_W-1:0] last_j_ff;       // Last value shown on j
   logic [via_pkg::DATA_W-1:0] last_k_ff;       // Last value shown on k

   // Idle read lines show the inverse, so stale data cannot pass
   assign rd_j_data_o = rd_en_i ? mem_ff[rd_j_i][rd_idx_i] : ~last_j_ff;
   assign rd_k_data_o = rd_en_i ? mem_ff[rd_k_i][rd_idx_i] : ~last_k_ff;

   // Plain always: the bench also preloads this array
   always @(posedge ref_clk_i) begin
      last_j_ff <= rd_j_data_o;
      last_k_ff <= rd_k_data_o;
      // Only the addressed element changes
      if (wr_en_i === 1'b1) begin
         mem_ff[wr_reg_i][wr_idx_i] <= wr_data_i;
      end
   end
endmodule
